// [rtl/tcmwt_pkg.sv]
/*
  shared constants, field positions and types of the mode and wake timing block.
  assumes one 200 MHz clock; slower rates come from microsecond and millisecond ticks.
*/
package tcmwt_pkg;
  localparam int CLK_NS      = 5;
  localparam int TICK_NS     = 1000;
  localparam int US_CYC      = TICK_NS / CLK_NS;      // cycles per microsecond tick
  localparam int US_PER_MS   = 1000;
  localparam int PWRUP_MS    = 2;                     // inhibit at nominal time
  localparam int UV_FLT_US   = 10;                    // inside 3..50 us
  localparam int UV_SLP_MS   = 300;                   // inside 200..400 ms
  localparam int WAKE_US     = 40;
  localparam int BUS_FLT_NS  = 1000;                  // inside 0.5..1.8 us
  localparam int BUS_FLT_CYC = BUS_FLT_NS / CLK_NS;
  localparam int WK_TMO_US   = 1000;                  // inside 0.5..2 ms
  localparam int SILENCE_MS  = 900;                   // inside 0.6..1.2 s
  localparam int INACT_MS    = 4 * 60 * 1000;         // 4 min, inside 3.75..5 min
  localparam int DTO_MS      = 3;                     // inside 1..5 ms
  localparam int TOGGLE_US   = 10;                    // full period
  localparam int WID_BASE_MS = 8;                     // fixed cut between 5 and 10 ms
  localparam int WIN_MS [4]  = '{850, 1125, 1687, 2250};
  localparam logic [7:0] CFG_ADDR  = 8'h11;
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam int         CFG_MODE  = 6;               // [7:6] wake pin mode
  localparam int         CFG_WID   = 2;               // [3:2] width select
  localparam int         CFG_WIN   = 0;               // [1:0] window select
  localparam logic [1:0] WAKE_PULSE_MODE = 2'h3;

  typedef enum logic [3:0] {
    M_PWRUP = 4'h1,
    M_STBY  = 4'h2,
    M_NORM  = 4'h4,
    M_SLP   = 4'h8
  } tcmwt_mode_e;

  typedef enum logic [1:0] {
    C_NONE = 2'h0,
    C_NORM = 2'h1,
    C_STBY = 2'h2,
    C_SLP  = 2'h3
  } tcmwt_cmd_e;
endpackage

// [rtl/tcmwt_tick_if.sv]
/*
  carries the microsecond and millisecond enable pulses between the block's modules.
  assumes both pulses are one cycle wide on the single block clock.
*/
interface tcmwt_tick_if;
  logic us;
  logic ms;
  modport src (output us, output ms);
  modport snk (input us, input ms);
endinterface

// [rtl/tcmwt_timebase.sv]
/*
  divider making one-cycle microsecond and millisecond ticks.
  assumes the 200 MHz block clock; P_US_PER_MS may be shortened in simulation (max 1024).
*/
module tcmwt_timebase
  import tcmwt_pkg::*;
#(
  parameter int P_US_PER_MS = US_PER_MS
)(
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  tcmwt_tick_if.src tk
);
  typedef struct packed {
    logic [7:0] cyc;
    logic [9:0] us;
    logic       us_t;
    logic       ms_t;
  } tcmwt_tb_s;

  tcmwt_tb_s q, d;

  // ms tick lands on the same cycle as the us tick that completes it
  always_comb
  begin
    d      = q;
    d.us_t = 1'b0;
    d.ms_t = 1'b0;
    if (q.cyc == 8'(US_CYC - 1))
    begin
      d.cyc  = 8'h0;
      d.us_t = 1'b1;
      if (q.us == 10'(P_US_PER_MS - 1))
      begin
        d.us   = 10'h0;
        d.ms_t = 1'b1;
      end
      else
        d.us = q.us + 10'h1;
    end
    else
      d.cyc = q.cyc + 8'h1;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      q <= '0;
    else
      q <= d;
  end

  assign tk.us = q.us_t;
  assign tk.ms = q.ms_t;
endmodule

// [rtl/tcmwt_wake_filter.sv]
/*
  local wake pin qualification: edge filter or pulse width and window check.
  assumes the pin is synchronous; high pulse is the active pulse in pulse mode.
*/
module tcmwt_wake_filter
  import tcmwt_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  tcmwt_tick_if.snk       tk,
  input  wire logic       i_arm,
  input  wire logic       i_pin,
  input  wire logic [7:0] i_cfg,
  output logic            o_wake
);
  typedef struct packed {
    logic        lvl;
    logic        pin;
    logic        hi;
    logic [5:0]  us_cnt;
    logic [11:0] ms_cnt;
    logic        wake;
  } tcmwt_wf_s;

  tcmwt_wf_s   q, d;
  logic [11:0] wid_min;
  logic [11:0] win_max;

  // single cut per select keeps the undefined band deterministic
  assign wid_min = 12'(WID_BASE_MS) << i_cfg[CFG_WID+:2];
  assign win_max = 12'(WIN_MS[i_cfg[CFG_WIN+:2]]);

  always_comb
  begin
    d      = q;
    d.wake = 1'b0;
    d.pin  = i_pin;
    if (!i_arm)
    begin
      d.hi     = 1'b0;
      d.us_cnt = 6'h0;
      d.ms_cnt = 12'h0;
      d.lvl    = i_pin;
    end
    else if (i_cfg[CFG_MODE+:2] == WAKE_PULSE_MODE)
    begin
      if (i_pin && !q.pin)
      begin
        d.hi     = 1'b1;
        d.ms_cnt = 12'h0;
      end
      else if (q.hi && i_pin && tk.ms && q.ms_cnt != 12'hfff)
        d.ms_cnt = q.ms_cnt + 12'h1;
      // judged on the falling edge: wide enough, yet ended inside the window
      if (q.hi && !i_pin)
      begin
        d.hi   = 1'b0;
        d.wake = (q.ms_cnt >= wid_min) && (q.ms_cnt < win_max);
      end
    end
    else if (i_pin == q.lvl)
    begin
      // back to the old level before 40 us: glitch dropped
      d.hi     = 1'b0;
      d.us_cnt = 6'h0;
    end
    else
    begin
      d.hi = 1'b1;
      // one extra tick since the first tick lands anywhere in its microsecond
      if (q.hi && tk.us)
      begin
        if (q.us_cnt == 6'(WAKE_US))
        begin
          d.wake   = 1'b1;
          d.lvl    = i_pin;
          d.hi     = 1'b0;
          d.us_cnt = 6'h0;
        end
        else
          d.us_cnt = q.us_cnt + 6'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      q <= '0;
    else
      q <= d;
  end

  assign o_wake = q.wake;
endmodule

// [rtl/tcmwt_top.sv]
/*
  mode sequencing, supply supervision, bus wake and pin timers of the transceiver.
  assumes synchronous inputs, decoded SPI commands and register strobes from outside.
*/
// What this block does
// - drive inhibit within 4 ms after main supply comes up, about 2 ms
// - undervoltage must persist 3 to 50 us before it counts
// - supply undervoltage lasting 200 to 400 ms sends the device to sleep
// - standby to normal command completes within 70 us
// - normal to sleep command completes within 200 us
// - normal to standby command completes within 70 us
// - leaving sleep, receive pin goes low within 100 us of supplies good
// - bus wake or local wake asserts inhibit within 100 us
// - sleep command from normal releases inhibit within 50 us
// - wake pin edge needs at least 40 us of qualification
// - wake pin pulses shorter than 10 us are noise
// - bus wake phases need 0.5 to 1.8 us; pattern times out after 0.5 to 2 ms
// - pulse mode accepts widths of at least 10, 20, 40 or 80 ms
// - pulse mode rejects widths up to 5, 10, 20 or 40 ms
// - window select bounds the pulse at 750-950 up to 2000-2500 ms
// - width and window checks apply only with wake pin mode 11b
// - widths between reject and accept limits may go either way
// - bus silence timer of 0.6 to 1.2 s restarts on each bus change
// - inactivity timer of 3.75 to 5 minutes supervises standby
// - bus biasing within 250 us of a dominant-recessive-dominant sequence
// - after bus wake, receive pin may toggle at a 5 to 15 us period
module tcmwt_top
  import tcmwt_pkg::*;
#(
  parameter int P_US_PER_MS = US_PER_MS,
  parameter int P_INACT_MS  = INACT_MS,
  parameter int P_WK_TMO_US = WK_TMO_US
)(
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_sup_uv,
  input  wire logic       i_cc_uv,
  input  wire logic       i_io_uv,
  input  wire logic       i_wake_pin,
  input  wire logic       i_bus_dom,
  input  wire logic       i_txd,
  input  wire logic       i_cmd_vld,
  input  wire logic [1:0] i_cmd,
  input  wire logic       i_rx_toggle_en,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic            o_inh,
  output logic [3:0]      o_mode,
  output logic            o_rxd,
  output logic            o_drv_en,
  output logic            o_bias_en,
  output logic            o_uv,
  output logic            o_local_wake,
  output logic            o_bus_wake,
  output logic            o_silence,
  output logic            o_dto,
  output logic [7:0]      o_reg_rdata
);
  localparam int INA_W = $clog2(P_INACT_MS + 1);
  localparam int TMO_W = $clog2(P_WK_TMO_US + 1);

  typedef struct packed {
    tcmwt_mode_e     mode;
    logic            inhibit_output;
    logic            rxd;
    logic            bias;
    logic            dto;
    logic            silence;
    logic            lwake;
    logic            bwake;
    logic            bus_prev;
    logic [1:0][3:0] uv_cnt;
    logic [1:0]      uv_f;
    logic [1:0]      pw_cnt;
    logic [8:0]      uvs_cnt;
    logic [7:0]      bph;
    logic [1:0]      bstage;
    logic [TMO_W-1:0] btmo;
    logic [9:0]      sil_cnt;
    logic [INA_W-1:0] ina_cnt;
    logic [1:0]      dto_cnt;
    logic [2:0]      tog_cnt;
    logic [7:0]      cfg;
    logic [7:0]      rdata;
  } tcmwt_top_s;

  tcmwt_top_s q, d;
  tcmwt_tick_if tk ();
  logic       lw_pulse;
  logic       wk_arm;
  logic       ph_ok;
  logic       bw_hit;
  logic       uvs_hit;
  logic       ina_hit;
  logic       tog_on;
  logic [1:0] uv_raw;

  // index 0 main supply, index 1 transceiver or io supply
  assign uv_raw = {i_cc_uv | i_io_uv, i_sup_uv};
  assign wk_arm = (q.mode == M_STBY) || (q.mode == M_SLP);
  assign ph_ok  = (i_bus_dom == q.bus_prev) && (q.bph == 8'(BUS_FLT_CYC - 1));
  assign tog_on = i_rx_toggle_en && q.bwake && (q.mode == M_STBY);

  tcmwt_timebase #(
    .P_US_PER_MS (P_US_PER_MS)
  ) u_timebase (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .tk       (tk)
  );

  tcmwt_wake_filter u_wake (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .tk       (tk),
    .i_arm    (wk_arm),
    .i_pin    (i_wake_pin),
    .i_cfg    (q.cfg),
    .o_wake   (lw_pulse)
  );

  // next state of the whole block
  always_comb
  begin
    d          = q;
    bw_hit     = 1'b0;
    uvs_hit    = 1'b0;
    ina_hit    = 1'b0;
    d.bus_prev = i_bus_dom;
    // release is immediate, assertion waits the full filter time
    for (int i = 0; i < 2; i++)
    begin
      if (!uv_raw[i])
      begin
        d.uv_cnt[i] = 4'h0;
        d.uv_f[i]   = 1'b0;
      end
      else if (tk.us && !q.uv_f[i])
      begin
        if (q.uv_cnt[i] == 4'(UV_FLT_US - 1))
          d.uv_f[i] = 1'b1;
        else
          d.uv_cnt[i] = q.uv_cnt[i] + 4'h1;
      end
    end
    // bus phase length, saturating once the filter time is met
    if (i_bus_dom != q.bus_prev)
      d.bph = 8'h0;
    else if (q.bph != 8'(BUS_FLT_CYC))
      d.bph = q.bph + 8'h1;
    // dominant, recessive, dominant; stage 1 wants recessive
    if (!wk_arm || (q.bstage != 2'h0 && tk.us && q.btmo == TMO_W'(P_WK_TMO_US - 1)))
    begin
      d.bstage = 2'h0;
      d.btmo   = '0;
    end
    else
    begin
      if (q.bstage != 2'h0 && tk.us)
        d.btmo = q.btmo + TMO_W'(1);
      if (ph_ok && (i_bus_dom == (q.bstage != 2'h1)))
      begin
        if (q.bstage == 2'h2)
        begin
          bw_hit   = 1'b1;
          d.bstage = 2'h0;
          d.btmo   = '0;
        end
        else
          d.bstage = q.bstage + 2'h1;
      end
    end
    // silence timer restarts on either bus edge
    if (i_bus_dom != q.bus_prev)
    begin
      d.sil_cnt = 10'h0;
      d.silence = 1'b0;
    end
    else if (tk.ms && !q.silence)
    begin
      if (q.sil_cnt == 10'(SILENCE_MS - 1))
        d.silence = 1'b1;
      else
        d.sil_cnt = q.sil_cnt + 10'h1;
    end
    // stuck dominant transmit; driver back once the input goes recessive
    if (i_txd || q.mode != M_NORM)
    begin
      d.dto_cnt = 2'h0;
      d.dto     = 1'b0;
    end
    else if (tk.ms && !q.dto)
    begin
      if (q.dto_cnt == 2'(DTO_MS - 1))
        d.dto = 1'b1;
      else
        d.dto_cnt = q.dto_cnt + 2'h1;
    end
    // supply trouble timer, only while the node is awake
    if (!q.uv_f[1] || !(q.mode == M_STBY || q.mode == M_NORM))
      d.uvs_cnt = 9'h0;
    else if (tk.ms)
    begin
      if (q.uvs_cnt == 9'(UV_SLP_MS - 1))
        uvs_hit = 1'b1;
      else
        d.uvs_cnt = q.uvs_cnt + 9'h1;
    end
    // any command or wake counts as activity
    if (q.mode != M_STBY || i_cmd_vld || lw_pulse || bw_hit)
      d.ina_cnt = '0;
    else if (tk.ms)
    begin
      if (q.ina_cnt == INA_W'(P_INACT_MS - 1))
        ina_hit = 1'b1;
      else
        d.ina_cnt = q.ina_cnt + INA_W'(1);
    end
    // receive pin: bus in normal, wake flag or toggle elsewhere
    if (!tog_on)
      d.tog_cnt = 3'h0;
    if (q.mode == M_NORM)
      d.rxd = !i_bus_dom;
    else if (tog_on)
    begin
      if (tk.us)
      begin
        if (q.tog_cnt == 3'(TOGGLE_US / 2 - 1))
        begin
          d.tog_cnt = 3'h0;
          d.rxd     = !q.rxd;
        end
        else
          d.tog_cnt = q.tog_cnt + 3'h1;
      end
    end
    else
      d.rxd = !(q.mode == M_STBY && (q.bwake || q.lwake));
    // configuration register; only the one address answers
    if (i_reg_wr && i_reg_addr == CFG_ADDR)
      d.cfg = i_reg_wdata;
    if (i_reg_rd)
      d.rdata = (i_reg_addr == CFG_ADDR) ? q.cfg : 8'h00;
    // mode sequencing; main supply loss overrides every mode, though the wake events below still set their flags and bias
    if (q.uv_f[0])
    begin
      d.mode   = M_PWRUP;
      d.inhibit_output    = 1'b0;
      d.pw_cnt = 2'h0;
      d.bias   = 1'b0;
    end
    else
    begin
      case (q.mode)
        M_PWRUP:
        begin
          // count only once the raw supply is back, never while its filter still runs
          if (uv_raw[0])
            d.pw_cnt = 2'h0;
          else if (tk.ms)
          begin
            if (q.pw_cnt == 2'(PWRUP_MS - 1))
            begin
              d.inhibit_output  = 1'b1;
              d.mode = M_STBY;
            end
            else
              d.pw_cnt = q.pw_cnt + 2'h1;
          end
        end
        M_STBY:
        begin
          if (uvs_hit || ina_hit || (i_cmd_vld && i_cmd == C_SLP))
          begin
            d.mode = M_SLP;
            d.inhibit_output  = 1'b0;
            d.bias = 1'b0;
          end
          else if (i_cmd_vld && i_cmd == C_NORM)
          begin
            d.mode  = M_NORM;
            d.bias  = 1'b1;
            d.lwake = 1'b0;
            d.bwake = 1'b0;
          end
        end
        M_NORM:
        begin
          if (uvs_hit || (i_cmd_vld && i_cmd == C_SLP))
          begin
            d.mode = M_SLP;
            d.inhibit_output  = 1'b0;
            d.bias = 1'b0;
          end
          else if (i_cmd_vld && i_cmd == C_STBY)
            d.mode = M_STBY;
        end
        M_SLP:
        begin
          if (!q.inhibit_output)
          begin
            if (lw_pulse || bw_hit)
              d.inhibit_output = 1'b1;
          end
          else if (!q.uv_f[1])
          begin
            d.mode = M_STBY;
            d.rxd  = 1'b0;
          end
        end
        default:
          d.mode = M_PWRUP;
      endcase
    end
    // wake events win over the clears above
    if (lw_pulse)
      d.lwake = 1'b1;
    if (bw_hit)
    begin
      d.bwake = 1'b1;
      d.bias  = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      q <= '{mode: M_PWRUP, rxd: 1'b1, cfg: CFG_RST, default: '0};
    else
      q <= d;
  end

  assign o_inh        = q.inhibit_output;
  assign o_mode       = q.mode;
  assign o_rxd        = q.rxd;
  assign o_drv_en     = (q.mode == M_NORM) && !q.dto;
  assign o_bias_en    = q.bias;
  assign o_uv         = |q.uv_f;
  assign o_local_wake = q.lwake;
  assign o_bus_wake   = q.bwake;
  assign o_silence    = q.silence;
  assign o_dto        = q.dto;
  assign o_reg_rdata  = q.rdata;

  // checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  property p_uv_filt;
    $rose(q.uv_f[1]) |-> $past(q.uv_cnt[1]) == 4'(UV_FLT_US - 1) && $past(tk.us);
  endproperty
  a_uv_filt: assert property (p_uv_filt) else $error("uv flag set early");

  property p_norm_in;
    q.mode == M_STBY && i_cmd_vld && i_cmd == C_NORM && !q.uv_f[0] && !uvs_hit && !ina_hit
      |=> o_mode == M_NORM && o_bias_en;
  endproperty
  a_norm_in: assert property (p_norm_in) else $error("normal entry missed");

  property p_sleep_in;
    q.mode == M_NORM && i_cmd_vld && i_cmd == C_SLP && !q.uv_f[0]
      |=> o_mode == M_SLP && !o_inh && !o_drv_en;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("sleep entry missed");

  property p_stby_in;
    q.mode == M_NORM && i_cmd_vld && i_cmd == C_STBY && !q.uv_f[0] && !uvs_hit
      |=> o_mode == M_STBY;
  endproperty
  a_stby_in: assert property (p_stby_in) else $error("standby entry missed");

  property p_wake_inh;
    q.mode == M_SLP && !q.inhibit_output && !q.uv_f[0] && (lw_pulse || bw_hit) |=> o_inh;
  endproperty
  a_wake_inh: assert property (p_wake_inh) else $error("inhibit not raised");

  property p_rxd_low;
    q.mode == M_SLP && q.inhibit_output && !q.uv_f[0] && !q.uv_f[1]
      |=> o_mode == M_STBY && !o_rxd ##1 o_mode != M_SLP;
  endproperty
  a_rxd_low: assert property (p_rxd_low) else $error("receive pin not low");

  property p_dto;
    q.mode == M_NORM && !i_txd && tk.ms && !q.dto && q.dto_cnt == 2'(DTO_MS - 1)
      |=> !o_drv_en && o_dto;
  endproperty
  a_dto: assert property (p_dto) else $error("driver not disabled");

  property p_bus_wake;
    $rose(o_bus_wake) |-> $past(q.bstage) == 2'h2 && $past(i_bus_dom) && o_bias_en;
  endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("bus wake without pattern");

  property p_silence;
    i_bus_dom != q.bus_prev |=> !o_silence [*2];
  endproperty
  a_silence: assert property (p_silence) else $error("silence not restarted");

  c_norm: cover property (q.mode == M_STBY ##1 q.mode == M_NORM);
  c_sleep: cover property (q.mode == M_NORM ##1 q.mode == M_SLP);
  c_bwake: cover property (bw_hit);
  c_lwake: cover property (q.mode == M_SLP && lw_pulse);
endmodule

// [tb/tcmwt_bus_model.sv]
/*
  far side bus model: plays one dominant, recessive, dominant burst on request.
  assumes the bus idles recessive between bursts, as a biased bus does.
*/
module tcmwt_bus_model
(
  input  wire logic        i_mclk,
  input  wire logic        i_go,
  input  wire logic [15:0] i_dom_cyc,
  input  wire logic [15:0] i_rec_cyc,
  output logic             o_bus_dom
);
  timeunit 1ns;
  timeprecision 1ps;

  // phases counted in cycles, edges on the falling clock edge; one process drives the bus
  initial
  begin
    o_bus_dom = 1'b0;
    forever
    begin
      @(posedge i_go);
      @(negedge i_mclk);
      o_bus_dom = 1'b1;
      repeat (i_dom_cyc) @(negedge i_mclk);
      o_bus_dom = 1'b0;
      repeat (i_rec_cyc) @(negedge i_mclk);
      o_bus_dom = 1'b1;
      repeat (i_dom_cyc) @(negedge i_mclk);
      o_bus_dom = 1'b0;
    end
  end
endmodule

// [tb/tcmwt_top_tb.sv]
/*
  bench for the mode and wake timing block: port tasks and checked test sequence.
  assumes shortened ms timers (4 us per ms) and the bus model on the bus input.
*/
module tcmwt_top_tb
  import tcmwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int US = US_CYC;
  localparam int MS = 4 * US;
  logic        i_mclk, i_arst_n, i_sup_uv, i_cc_uv, i_io_uv, i_wake_pin, i_txd;
  logic        i_cmd_vld, i_rx_toggle_en, i_reg_wr, i_reg_rd, bus_dom, bus_go;
  logic [1:0]  i_cmd;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, rd;
  logic [3:0]  o_mode;
  logic        o_inh, o_rxd, o_drv_en, o_bias_en, o_uv, o_local_wake, o_bus_wake;
  logic        o_silence, o_dto;
  logic [15:0] dom_cyc, rec_cyc;
  int          bad_count, n_tests, k;

  // ms timers shortened so pulse tests fit the run
  tcmwt_top #(.P_US_PER_MS(4), .P_INACT_MS(100), .P_WK_TMO_US(50)) tcmwt_top_inst (
    .i_mclk, .i_arst_n, .i_sup_uv, .i_cc_uv, .i_io_uv, .i_wake_pin, .i_bus_dom(bus_dom),
    .i_txd, .i_cmd_vld, .i_cmd, .i_rx_toggle_en, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_inh, .o_mode, .o_rxd, .o_drv_en, .o_bias_en, .o_uv, .o_local_wake,
    .o_bus_wake, .o_silence, .o_dto, .o_reg_rdata);

  tcmwt_bus_model tcmwt_bus_model_inst (.i_mclk, .i_go(bus_go), .i_dom_cyc(dom_cyc),
    .i_rec_cyc(rec_cyc), .o_bus_dom(bus_dom));

  // 200 MHz clock
  always #2.5 i_mclk = ~i_mclk;

  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
  endtask

  // read data waits one spare cycle; it holds until the next read anyway
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_mclk);
    i_reg_rd = 1'b0;
    @(negedge i_mclk);
    d = o_reg_rdata;
  endtask

  task automatic send_cmd(input logic [1:0] c);
    @(negedge i_mclk);
    i_cmd_vld = 1'b1;
    i_cmd = c;
    @(negedge i_mclk);
    i_cmd_vld = 1'b0;
  endtask

  task automatic pin_pulse(input int n);
    @(negedge i_mclk);
    i_wake_pin = 1'b1;
    idle(n);
    i_wake_pin = 1'b0;
  endtask

  task automatic burst(input logic [15:0] d, input logic [15:0] r);
    @(negedge i_mclk);
    dom_cyc = d;
    rec_cyc = r;
    bus_go = 1'b1;
    @(negedge i_mclk);
    bus_go = 1'b0;
  endtask

  // watchdog: run takes near 90k cycles
  initial
  begin
    #500000;
    bad_count++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    {i_mclk, i_arst_n, i_cc_uv, i_io_uv, i_wake_pin, i_cmd_vld, i_rx_toggle_en} = '0;
    {i_reg_wr, i_reg_rd, bus_go, i_cmd, i_reg_addr, i_reg_wdata, dom_cyc, rec_cyc} = '0;
    {i_sup_uv, i_txd} = 2'h3;
    bad_count = 0;
    n_tests = 0;
    repeat (5) @(negedge i_mclk);
    chk("rst_flags", 8'h40, {o_inh, o_rxd, o_drv_en, o_bias_en, o_uv, o_local_wake,
      o_bus_wake, o_dto});
    chk("rst_mode", {4'h0, M_PWRUP}, {4'h0, o_mode});
    i_arst_n = 1'b1;
    // inhibit must stay off while the main supply is still low, filter running or not
    idle(9 * US);
    chk("inh_sup_low", 8'h00, {7'h0, o_inh});
    idle(11 * US);
    chk("uv_sup", 8'h01, {7'h0, o_uv});
    chk("inh_sup_uv", 8'h00, {7'h0, o_inh});
    // supply comes up: inhibit within the bound, then standby
    i_sup_uv = 1'b0;
    for (k = 0; k < 4 * MS && o_inh !== 1'b1; k++) @(negedge i_mclk);
    chk("inh_pwrup", 8'h01, {7'h0, o_inh});
    for (k = 0; k < MS && o_mode !== M_STBY; k++) @(negedge i_mclk);
    chk("mode_stby", {4'h0, M_STBY}, {4'h0, o_mode});
    // config register, unmapped address ignored
    reg_rd(CFG_ADDR, rd);
    chk("cfg_rst", CFG_RST, rd);
    reg_wr(CFG_ADDR, 8'hc4);
    reg_wr(8'h12, 8'hff);
    reg_rd(CFG_ADDR, rd);
    chk("cfg_rw", 8'hc4, rd);
    reg_rd(8'h12, rd);
    chk("unmapped", 8'h00, rd);
    // pulse mode: width select 1 then 0
    pin_pulse(10 * MS);
    idle(4);
    chk("pw_sel1_10ms", 8'h00, {7'h0, o_local_wake});
    reg_wr(CFG_ADDR, 8'hc0);
    pin_pulse(5 * MS);
    idle(4);
    chk("pw_sel0_5ms", 8'h00, {7'h0, o_local_wake});
    pin_pulse(10 * MS);
    idle(4);
    chk("pw_sel0_10ms", 8'h01, {7'h0, o_local_wake});
    // undervoltage filter, release is immediate
    i_cc_uv = 1'b1;
    idle(2 * US);
    chk("uv_2us", 8'h00, {7'h0, o_uv});
    idle(10 * US);
    chk("uv_12us", 8'h01, {7'h0, o_uv});
    i_cc_uv = 1'b0;
    idle(2);
    chk("uv_release", 8'h00, {7'h0, o_uv});
    i_io_uv = 1'b1;
    idle(2);
    chk("io_uv_new", 8'h00, {7'h0, o_uv});
    idle(12 * US);
    chk("io_uv_12us", 8'h01, {7'h0, o_uv});
    i_io_uv = 1'b0;
    send_cmd(C_NORM);
    chk("to_norm", {4'h0, M_NORM}, {4'h0, o_mode});
    chk("norm_flags", 8'h0e, {4'h0, o_inh, o_drv_en, o_bias_en, o_local_wake});
    // transmit held dominant
    i_txd = 1'b0;
    idle(MS);
    chk("dto_early", 8'h00, {7'h0, o_dto});
    for (k = 0; k < 3 * MS && o_dto !== 1'b1; k++) @(negedge i_mclk);
    chk("dto_on", 8'h02, {6'h0, o_dto, o_drv_en});
    i_txd = 1'b1;
    idle(2);
    chk("dto_off", 8'h01, {6'h0, o_dto, o_drv_en});
    send_cmd(C_STBY);
    chk("to_stby", {4'h0, M_STBY}, {4'h0, o_mode});
    // edge mode local wake: glitch, then a held level
    reg_wr(CFG_ADDR, 8'h00);
    pin_pulse(5 * US);
    idle(42 * US);
    chk("lw_glitch", 8'h00, {7'h0, o_local_wake});
    i_wake_pin = 1'b1;
    idle(39 * US);
    chk("lw_39us", 8'h00, {7'h0, o_local_wake});
    idle(4 * US);
    chk("lw_43us", 8'h01, {7'h0, o_local_wake});
    send_cmd(C_NORM);
    send_cmd(C_SLP);
    chk("to_sleep", {M_SLP, 4'h0}, {o_mode, 3'h0, o_inh});
    // wake from sleep by pin edge
    i_wake_pin = 1'b0;
    for (k = 0; k < 100 * US && o_inh !== 1'b1; k++) @(negedge i_mclk);
    chk("slp_inh", 8'h01, {7'h0, o_inh});
    idle(2);
    chk("slp_stby", {M_STBY, 4'h0}, {o_mode, 3'h0, o_rxd});
    // bus wake: short phases, timed out pattern, then a good one
    i_rx_toggle_en = 1'b1;
    burst(16'd60, 16'd60);
    idle(20 * US);
    chk("bw_short", 8'h00, {7'h0, o_bus_wake});
    burst(16'(6 * US), 16'(55 * US));
    idle(125 * US);
    chk("bw_tmo", 8'h00, {7'h0, o_bus_wake});
    burst(16'(6 * US), 16'(6 * US));
    for (k = 0; k < 250 * US && o_bus_wake !== 1'b1; k++) @(negedge i_mclk);
    chk("bw_bias", 8'h03, {5'h0, o_silence, o_bus_wake, o_bias_en});
    // receive pin toggles every half period
    rd[0] = o_rxd;
    for (k = 0; k < 6 * US && o_rxd === rd[0]; k++) @(negedge i_mclk);
    rd[0] = o_rxd;
    idle(4 * US);
    chk("tog_hold", {7'h0, rd[0]}, {7'h0, o_rxd});
    idle(2 * US);
    chk("tog_flip", {7'h0, ~rd[0]}, {7'h0, o_rxd});
    tally_and_finish();
  end
endmodule
